/* File: src/sdb_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module sdb_bank
	import sdb_pkg::*;
#(
	parameter logic [3:0] CHIP_CODE = 4'h5, // arbitrary value
	parameter logic [2:0] REV_CODE  = 3'h1, // arbitrary value
	parameter longint     PFM_COUNT = PFM_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        spi_sck_i,
	input  wire logic        spi_cs_n_i,
	input  wire logic        spi_mosi_i,
	output logic             spi_miso_o,
	output logic             spi_miso_oe_o,
	input  wire logic        init_done_i,
	input  wire logic [1:0]  mode_pins_i,
	input  wire logic [11:0] mon_fail_i,
	input  wire logic [7:0]  loop_evt_i,
	input  wire logic [7:0]  freq_code_a_i,
	input  wire logic [7:0]  freq_code_b_i,
	input  wire logic [7:0]  sync_stat_a_i,
	input  wire logic [7:0]  sync_stat_b_i,
	input  wire logic [1:0]  auto_src_i,
	output logic [7:0]       pin_control_select_o,
	output logic [1:0]       loop_mode_o,
	output logic [1:0]       source_sel_o,
	output logic [2:0]       switch_fault_o,
	output logic [7:0]       range_limit_a_o,
	output logic [7:0]       range_limit_b_o,
	output logic [7:0]       soak_input_mask_o,
	output logic [7:0]       soak_timing_o,
	output logic [7:0]       loop_filter_control_o,
	output logic [7:0]       loop_holdover_control_o,
	output logic [7:0]       restore_wait_time_o,
	output logic [2:0]       revert_enables_o,
	output logic [7:0]       source_priority_a_o,
	output logic [7:0]       source_priority_b_o,
	output logic             ref_fault_pending_o,
	output logic             loop_pending_o,
	output logic             precise_window_tick_o
);
	localparam int PFM_W = $clog2(PFM_COUNT + 1);
	localparam logic [PFM_W-1:0] PFM_LAST = PFM_W'(PFM_COUNT - 1);

	typedef struct packed {
		logic [NRW-1:0][7:0] rw;
		logic [1:0]          mode_m;
		logic [1:0]          mode_s;
		logic [PFM_W-1:0]    pfm_cnt;
		logic                pfm_tick;
		logic [2:0]          sw_fault;
	} sdb_bank_t;
	sdb_bank_t s_ff, nxt_s;

	logic [ADDR_W-1:0] addr;
	logic [7:0]        wdata;
	logic              wr_stb;
	logic              rd_stb;
	logic [7:0]        rdata;
	logic [7:0]        loop_q;
	logic [7:0]        mon_a_q;
	logic [7:0]        mon_b_q;
	logic [7:0]        loop_clr;
	logic [7:0]        mon_a_clr;
	logic [7:0]        mon_b_clr;
	logic [7:0]        ref_status;
	logic [11:0]       mon_gated;
	logic [1:0]        eff_mode;
	logic              pfm_restart;

	// serial register port
	sdb_spi_slave u_spi (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.sck_i    (spi_sck_i),
		.cs_n_i   (spi_cs_n_i),
		.mosi_i   (spi_mosi_i),
		.miso_o   (spi_miso_o),
		.miso_oe_o(spi_miso_oe_o),
		.rdata_i  (rdata),
		.addr_o   (addr),
		.wdata_o  (wdata),
		.wr_stb_o (wr_stb),
		.rd_stb_o (rd_stb)
	);

	// sticky clears: a read clears all, a write of ones clears those bits
	always_comb begin
		loop_clr  = 8'h00;
		mon_a_clr = 8'h00;
		mon_b_clr = 8'h00;
		if (rd_stb || wr_stb) begin
			if (addr == A_LOOP_IRQ) begin
				loop_clr = rd_stb ? 8'hFF : wdata;
			end
			if (addr == A_MON_A) begin
				mon_a_clr = rd_stb ? 8'hFF : wdata;
			end
			if (addr == A_MON_B) begin
				mon_b_clr = rd_stb ? 8'hFF : wdata;
			end
		end
	end

	// loop event status
	sdb_sticky #(.W(8), .RST(RST_LOOP_IRQ)) u_loop_stk (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.set_i  (loop_evt_i),
		.clr_i  (loop_clr),
		.q_o    (loop_q)
	);

	// monitor fault flags, refs a and b; bit order scm, cfm, pfm, gst per nibble
	sdb_sticky #(.W(8), .RST(RST_MON)) u_mon_a_stk (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.set_i  (mon_fail_i[7:0]),
		.clr_i  (mon_a_clr),
		.q_o    (mon_a_q)
	);

	// monitor fault flags, third ref
	sdb_sticky #(.W(8), .RST(RST_MON)) u_mon_b_stk (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.set_i  ({4'h0, mon_fail_i[11:8]}),
		.clr_i  (mon_b_clr),
		.q_o    (mon_b_q)
	);

	// per-reference fault summary through the monitor masks
	always_comb begin
		mon_gated  = {mon_b_q[3:0], mon_a_q} & {s_ff.rw[I_MON_MSK_B][3:0], s_ff.rw[I_MON_MSK_A]};
		ref_status = REF_IRQ_HIGH;
		for (int r = 0; r < 3; r++) begin
			ref_status[r] = |mon_gated[r*FLAGS_PER_REF +: FLAGS_PER_REF];
		end
	end

	// mode source: register or synchronised pins
	assign eff_mode = s_ff.rw[I_PIN][PIN_MODE_BIT] ? s_ff.mode_s : s_ff.rw[I_MODE][1:0];
	assign pfm_restart = |(mon_fail_i & SC_FLAG_MASK);

	// read data mux
	always_comb begin
		rdata = 8'h00;
		for (int i = 0; i < NRW; i++) begin
			if (addr == RW_ADDR[i]) begin
				rdata = s_ff.rw[i];
			end
		end
		case (addr)
			A_ID:       rdata = {CHIP_CODE, REV_CODE, init_done_i};
			A_REF_IRQ:  rdata = ref_status;
			A_LOOP_IRQ: rdata = loop_q;
			A_MON_A:    rdata = mon_a_q;
			A_MON_B:    rdata = mon_b_q;
			A_FREQ_A:   rdata = freq_code_a_i;
			A_FREQ_B:   rdata = freq_code_b_i;
			A_SYNC_A:   rdata = sync_stat_a_i;
			A_SYNC_B:   rdata = sync_stat_b_i;
			A_SRC_SEL: begin
				if (eff_mode == MODE_AUTO) begin
					rdata = {6'h00, auto_src_i};
				end
			end
			default: ;
		endcase
	end

	// register writes, pin sync, switch faults, precise window timer
	always_comb begin
		nxt_s        = s_ff;
		nxt_s.mode_m = mode_pins_i;
		nxt_s.mode_s = s_ff.mode_m;
		for (int i = 0; i < NRW; i++) begin
			if (wr_stb && addr == RW_ADDR[i]) begin
				nxt_s.rw[i] = wdata;
			end
		end
		for (int r = 0; r < 3; r++) begin
			nxt_s.sw_fault[r] = |(mon_fail_i[r*FLAGS_PER_REF +: FLAGS_PER_REF]
				& s_ff.rw[I_SW_MSK][SW_MSK_LSB +: FLAGS_PER_REF]);
		end
		nxt_s.pfm_tick = 1'b0;
		if (pfm_restart) begin
			nxt_s.pfm_cnt = '0;
		end else if (s_ff.pfm_cnt == PFM_LAST) begin
			nxt_s.pfm_cnt  = '0;
			nxt_s.pfm_tick = 1'b1;
		end else begin
			nxt_s.pfm_cnt = s_ff.pfm_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_ff <= '{rw: RW_RST, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// outputs
	assign pin_control_select_o    = s_ff.rw[I_PIN];
	assign loop_mode_o             = eff_mode;
	assign source_sel_o            = (eff_mode == MODE_AUTO) ? auto_src_i : s_ff.rw[I_SRC][1:0];
	assign switch_fault_o          = s_ff.sw_fault;
	assign range_limit_a_o         = s_ff.rw[I_LIM_A];
	assign range_limit_b_o         = s_ff.rw[I_LIM_B];
	assign soak_input_mask_o       = s_ff.rw[I_SOAK_MSK];
	assign soak_timing_o           = s_ff.rw[I_SOAK_TIM];
	assign loop_filter_control_o   = s_ff.rw[I_FILT];
	assign loop_holdover_control_o = s_ff.rw[I_HOLD];
	assign restore_wait_time_o     = s_ff.rw[I_WAIT];
	assign revert_enables_o        = s_ff.rw[I_REV][2:0];
	assign source_priority_a_o     = s_ff.rw[I_PRI_A];
	assign source_priority_b_o     = s_ff.rw[I_PRI_B];
	assign ref_fault_pending_o     = |(ref_status & s_ff.rw[I_REF_MSK]);
	assign loop_pending_o          = |(loop_q & s_ff.rw[I_LOOP_MSK]);
	assign precise_window_tick_o   = s_ff.pfm_tick;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_id_ready;
		(addr == A_ID) |-> (rdata[ID_READY_BIT] == init_done_i && rdata[7:4] == CHIP_CODE);
	endproperty
	a_id_ready: assert property (p_id_ready) else $error("id read wrong");

	property p_pin_mode;
		(s_ff.rw[I_PIN][PIN_MODE_BIT] && $stable(mode_pins_i)) [*3] |-> loop_mode_o == mode_pins_i;
	endproperty
	a_pin_mode: assert property (p_pin_mode) else $error("pin mode not followed");

	property p_ref_mask_off;
		s_ff.rw[I_REF_MSK] == 8'h00 |-> !ref_fault_pending_o;
	endproperty
	a_ref_mask_off: assert property (p_ref_mask_off) else $error("masked ref fault leaks");

	property p_set_wins;
		loop_evt_i != 8'h00 |=> (loop_q & $past(loop_evt_i)) == $past(loop_evt_i);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("loop event lost");

	property p_sticky_hold;
		!(rd_stb || wr_stb) |=> (loop_q & $past(loop_q)) == $past(loop_q) && (mon_a_q & $past(mon_a_q)) == $past(mon_a_q);
	endproperty
	a_sticky_hold: assert property (p_sticky_hold) else $error("sticky bit dropped");

	property p_read_clears;
		rd_stb && addr == A_MON_A && mon_fail_i[7:0] == 8'h00 |=> mon_a_q == 8'h00;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not clear flags");

	sequence s_write_pri_a;
		wr_stb && addr == RW_ADDR[I_PRI_A];
	endsequence
	property p_write_takes;
		s_write_pri_a |=> source_priority_a_o == $past(wdata) ##1 source_priority_a_o == $past(wdata, 2);
	endproperty
	a_write_takes: assert property (p_write_takes) else $error("priority write lost");

	property p_manual_src;
		eff_mode == MODE_MANUAL |-> source_sel_o == s_ff.rw[I_SRC][1:0];
	endproperty
	a_manual_src: assert property (p_manual_src) else $error("manual source not honoured");

	property p_switch_mask;
		s_ff.rw[I_SW_MSK] == 8'h00 |=> switch_fault_o == 3'h0;
	endproperty
	a_switch_mask: assert property (p_switch_mask) else $error("masked fault drives switching");

	property p_pfm_restart;
		pfm_restart |=> !precise_window_tick_o [*2];
	endproperty
	a_pfm_restart: assert property (p_pfm_restart) else $error("window not restarted");

	property p_read_keeps_new;
		rd_stb && addr == A_LOOP_IRQ |=> loop_q == $past(loop_evt_i);
	endproperty
	a_read_keeps_new: assert property (p_read_keeps_new) else $error("read clear lost a new event");

	property p_mon_b_read;
		rd_stb && addr == A_MON_B |=> mon_b_q == {4'h0, $past(mon_fail_i[2*FLAGS_PER_REF +: FLAGS_PER_REF])};
	endproperty
	a_mon_b_read: assert property (p_mon_b_read) else $error("third source flags not cleared");

	property p_ro_write_ignored;
		wr_stb && addr == A_FREQ_A |=> s_ff.rw == $past(s_ff.rw);
	endproperty
	a_ro_write_ignored: assert property (p_ro_write_ignored) else $error("read-only write changed a register");

	property p_ref_status_read;
		addr == A_REF_IRQ |-> (rdata & REF_IRQ_HIGH) == REF_IRQ_HIGH
			&& rdata[0] == |(mon_a_q[FLAGS_PER_REF-1:0] & s_ff.rw[I_MON_MSK_A][FLAGS_PER_REF-1:0]);
	endproperty
	a_ref_status_read: assert property (p_ref_status_read) else $error("reference status read wrong");

	property p_switch_follows;
		(mon_fail_i[2*FLAGS_PER_REF +: FLAGS_PER_REF]
			& s_ff.rw[I_SW_MSK][SW_MSK_LSB +: FLAGS_PER_REF]) != 4'h0 |=> switch_fault_o[2];
	endproperty
	a_switch_follows: assert property (p_switch_follows) else $error("unmasked fault ignored");

	property p_auto_src;
		eff_mode == MODE_AUTO |-> source_sel_o == auto_src_i;
	endproperty
	a_auto_src: assert property (p_auto_src) else $error("automatic source not followed");

	property p_tick_single;
		precise_window_tick_o |=> !precise_window_tick_o;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("window tick longer than one cycle");
endmodule
`default_nettype wire

/* File: src/sdb_pkg.sv */
package sdb_pkg;
	// register offsets, seven address bits on the serial port
	localparam int          ADDR_W      = 7;
	localparam logic [6:0]  A_ID        = 7'h00;
	localparam logic [6:0]  A_PIN_CTL   = 7'h01;
	localparam logic [6:0]  A_REF_IRQ   = 7'h02;
	localparam logic [6:0]  A_LOOP_IRQ  = 7'h03;
	localparam logic [6:0]  A_MON_A     = 7'h05;
	localparam logic [6:0]  A_MON_B     = 7'h06;
	localparam logic [6:0]  A_FREQ_A    = 7'h10;
	localparam logic [6:0]  A_FREQ_B    = 7'h11;
	localparam logic [6:0]  A_SYNC_A    = 7'h14;
	localparam logic [6:0]  A_SYNC_B    = 7'h15;
	localparam logic [6:0]  A_SRC_SEL   = 7'h20;
	// read-write registers: offsets, reset values, slot indices
	localparam int NRW = 18;
	localparam logic [NRW-1:0][6:0] RW_ADDR = {7'h25, 7'h24, 7'h23, 7'h22, 7'h21, 7'h20, 7'h1F, 7'h1E, 7'h1D,
		7'h1C, 7'h1A, 7'h17, 7'h16, 7'h0D, 7'h0C, 7'h0A, 7'h09, 7'h01};
	localparam logic [NRW-1:0][7:0] RW_RST = {8'h32, 8'h10, 8'h00, 8'h00, 8'h3C, 8'h00, 8'h01, 8'h00, 8'h00,
		8'h1A, 8'hFF, 8'h33, 8'h33, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
	localparam int I_PIN = 0, I_REF_MSK = 1, I_LOOP_MSK = 2, I_MON_MSK_A = 3, I_MON_MSK_B = 4;
	localparam int I_LIM_A = 5, I_LIM_B = 6, I_SOAK_MSK = 7, I_SOAK_TIM = 8, I_FILT = 9, I_HOLD = 10;
	localparam int I_MODE = 11, I_SRC = 12, I_SW_MSK = 13, I_WAIT = 14, I_REV = 15, I_PRI_A = 16, I_PRI_B = 17;
	// reset values of status registers
	localparam logic [7:0]  RST_LOOP_IRQ = 8'h70;
	localparam logic [7:0]  RST_MON      = 8'hFF;
	localparam logic [7:0]  REF_IRQ_HIGH = 8'hF8;
	// field positions
	localparam int          ID_READY_BIT = 0;
	localparam int          PIN_MODE_BIT = 0;
	localparam int          FLAGS_PER_REF = 4;
	localparam int          SW_MSK_LSB   = 2;
	localparam logic [11:0] SC_FLAG_MASK = 12'h333; // single-cycle and coarse flags, all refs
	// monitor limits
	localparam int          SCM_DEV_PCT  = 50;
	localparam int          CFM_CHG_PCT  = 3;
	// timing
	localparam longint      CLK_HZ       = 10_000_000;
	localparam longint      PFM_TIME_S   = 10;
	localparam longint      PFM_CYC      = PFM_TIME_S * CLK_HZ;
	typedef enum logic [1:0] {MODE_MANUAL, MODE_AUTO, MODE_HOLDOVER, MODE_FREERUN} sdb_mode_t;
endpackage

/* File: src/sdb_spi_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module sdb_spi_slave
	import sdb_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              sck_i,
	input  wire logic              cs_n_i,
	input  wire logic              mosi_i,
	output logic                   miso_o,
	output logic                   miso_oe_o,
	input  wire logic [7:0]        rdata_i,
	output logic      [ADDR_W-1:0] addr_o,
	output logic      [7:0]        wdata_o,
	output logic                   wr_stb_o,
	output logic                   rd_stb_o
);
	typedef struct packed {
		logic              sck_m, sck_s, sck_p;
		logic              cs_m, cs_s;
		logic              mosi_m, mosi_s;
		logic [2:0]        cnt;
		logic              data_ph;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        rx;
		logic [7:0]        tx;
		logic              wr_stb;
		logic              rd_stb;
		logic              ld; // burst read-ahead load, no clear strobe
	} sdb_spi_t;
	sdb_spi_t s_ff, nxt_s;
	logic rise, fall;

	// mode 0 framing: command byte {rd, addr}, then data bytes with auto increment
	always_comb begin
		nxt_s        = s_ff;
		nxt_s.wr_stb = 1'b0;
		nxt_s.rd_stb = 1'b0;
		nxt_s.ld     = 1'b0;
		nxt_s.sck_m  = sck_i;
		nxt_s.sck_s  = s_ff.sck_m;
		nxt_s.sck_p  = s_ff.sck_s;
		nxt_s.cs_m   = cs_n_i;
		nxt_s.cs_s   = s_ff.cs_m;
		nxt_s.mosi_m = mosi_i;
		nxt_s.mosi_s = s_ff.mosi_m;
		rise = s_ff.sck_s & ~s_ff.sck_p;
		fall = ~s_ff.sck_s & s_ff.sck_p;
		if (s_ff.rd_stb || s_ff.ld) begin
			nxt_s.tx = rdata_i;
		end
		if (s_ff.wr_stb) begin
			nxt_s.addr = s_ff.addr + 7'h01;
		end
		if (s_ff.cs_s) begin
			nxt_s.cnt     = 3'h0;
			nxt_s.data_ph = 1'b0;
		end else if (rise) begin
			nxt_s.rx  = {s_ff.rx[6:0], s_ff.mosi_s};
			nxt_s.cnt = s_ff.cnt + 3'h1;
			if (s_ff.cnt == 3'h7) begin
				if (!s_ff.data_ph) begin
					nxt_s.data_ph = 1'b1;
					nxt_s.rd      = s_ff.rx[6];
					nxt_s.addr    = {s_ff.rx[5:0], s_ff.mosi_s};
					nxt_s.rd_stb  = s_ff.rx[6];
				end else if (s_ff.rd) begin
					// read ahead quietly: the host may never clock this byte out
					nxt_s.addr   = s_ff.addr + 7'h01;
					nxt_s.ld     = 1'b1;
				end else begin
					nxt_s.wr_stb = 1'b1;
				end
			end
		end else if (fall && s_ff.data_ph && s_ff.cnt != 3'h0) begin
			nxt_s.tx = {s_ff.tx[6:0], 1'b0};
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_ff <= '{sck_m: 1'b0, sck_s: 1'b0, sck_p: 1'b0, cs_m: 1'b1, cs_s: 1'b1, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign miso_o    = s_ff.tx[7];
	assign miso_oe_o = ~s_ff.cs_s;
	assign addr_o    = s_ff.addr;
	assign wdata_o   = s_ff.rx;
	assign wr_stb_o  = s_ff.wr_stb;
	assign rd_stb_o  = s_ff.rd_stb;
endmodule
`default_nettype wire

/* File: src/sdb_sticky.sv */
`timescale 1ns/1ps
`default_nettype none
module sdb_sticky #(
	parameter int         W   = 8,
	parameter logic [7:0] RST = 8'hFF
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] set_i,
	input  wire logic [W-1:0] clr_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] q;
	} sdb_stk_t;
	sdb_stk_t s_ff, nxt_s;

	// set beats a clear in the same cycle
	always_comb begin
		nxt_s   = s_ff;
		nxt_s.q = (s_ff.q & ~clr_i) | set_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_ff.q <= RST[W-1:0];
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign q_o = s_ff.q;
endmodule
`default_nettype wire

/* File: tb/sdb_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sdb_spi_host #(
	parameter int HALF = 6
) (
	input  wire logic clk_i,
	input  wire logic miso_i,
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      mosi_o
);
	// idle: serial clock parked low, not selected
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// step n clocks, land just after the edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#10;
	endtask
	// open a frame
	task automatic start();
		step(1);
		cs_n_o = 1'b0;
		step(HALF);
	endtask
	// mode 0 byte, msb first, device data taken on the rise
	task automatic xbyte(input logic [7:0] w, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			mosi_o = w[i];
			step(HALF);
			sck_o = 1'b1;
			r[i] = miso_i;
			step(HALF);
			sck_o = 1'b0;
		end
	endtask
	// close a frame; inverted data line stops showing the last bit
	task automatic stop();
		step(HALF);
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		step(HALF);
	endtask
endmodule
`default_nettype wire

/* File: tb/test_sync_dpll_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module test_sync_dpll_register_bank;
	localparam int PRECISE_FREQUENCY_CHECK = 20;
	localparam logic [17:0][6:0] RA = {7'h01, 7'h09, 7'h0A, 7'h0C, 7'h0D, 7'h16, 7'h17, 7'h1A, 7'h1C,
		7'h1D, 7'h1E, 7'h1F, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25};
	localparam logic [17:0][7:0] RR = {8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h33, 8'h33, 8'hFF, 8'h1A,
		8'h00, 8'h00, 8'h01, 8'h00, 8'h3C, 8'h00, 8'h00, 8'h10, 8'h32};
	logic        clk, rst_n, sck, cs_n, mosi, miso, moe, init_done, refp, loopp, tck;
	logic [1:0]  mpins, asrc, mode, src;
	logic [2:0]  swf, rev;
	logic [11:0] mfail;
	logic [7:0]  evt, fa, fb, sa, sb, psel, lim_a, pri_a, pri_b, v;
	logic [7:0]  lim_b, smsk, stim, filt, hold, wtr;
	int          err_total, cmp_count, n;

	sdb_bank #(
		.CHIP_CODE(4'h9), // arbitrary value
		.REV_CODE (3'h2), // arbitrary value
		.PFM_COUNT(PRECISE_FREQUENCY_CHECK)
	) dut (
		.clk_i(clk), .rst_n_i(rst_n), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
		.spi_miso_o(miso), .spi_miso_oe_o(moe), .init_done_i(init_done), .mode_pins_i(mpins),
		.mon_fail_i(mfail), .loop_evt_i(evt), .freq_code_a_i(fa), .freq_code_b_i(fb),
		.sync_stat_a_i(sa), .sync_stat_b_i(sb), .auto_src_i(asrc), .pin_control_select_o(psel),
		.loop_mode_o(mode), .source_sel_o(src), .switch_fault_o(swf), .range_limit_a_o(lim_a),
		.range_limit_b_o(lim_b), .soak_input_mask_o(smsk), .soak_timing_o(stim), .loop_filter_control_o(filt),
		.loop_holdover_control_o(hold), .restore_wait_time_o(wtr), .revert_enables_o(rev),
		.source_priority_a_o(pri_a), .source_priority_b_o(pri_b), .ref_fault_pending_o(refp),
		.loop_pending_o(loopp), .precise_window_tick_o(tck)
	);
	sdb_spi_host host (.clk_i(clk), .miso_i(miso), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));

	// free-running system clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#10;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		host.start();
		host.xbyte({1'b0, a}, r);
		host.xbyte(d, r);
		host.stop();
	endtask
	task automatic rc(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] r;
		host.start();
		host.xbyte({1'b1, a}, r);
		host.xbyte(8'h00, r);
		host.stop();
		chk(r, exp);
	endtask
	// cycles until the next window tick, bounded
	task automatic gap(output int k);
		k = 0;
		while (tck !== 1'b1 && k < 100) begin
			step(1);
			k++;
		end
	endtask
	function automatic logic [7:0] pat(input logic [6:0] a);
		return {a[3:0], ~a[3:0]};
	endfunction
	// hang guard
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		summarize();
	end
	// main sequence
	initial begin
		{rst_n, init_done, mpins, asrc, mfail, evt} = '0;
		{fa, fb, sa, sb} = {8'h3C, 8'hA5, 8'h5A, 8'hC3};
		step(8);
		rst_n = 1'b1;
		step(3);
		for (int i = 0; i < 18; i++) rc(RA[i], RR[i]);
		rc(7'h02, 8'hFF);
		chk({7'h00, refp}, 8'h00);
		wr(7'h09, 8'h01);
		chk({7'h00, refp}, 8'h01);
		rc(7'h03, 8'h70);
		rc(7'h03, 8'h00);
		rc(7'h05, 8'hFF);
		rc(7'h05, 8'h00);
		rc(7'h06, 8'hFF);
		rc(7'h06, 8'h00);
		rc(7'h02, 8'hF8);
		chk({7'h00, refp}, 8'h00);
		rc(7'h00, 8'h94);
		init_done = 1'b1;
		rc(7'h00, 8'h95);
		// transient coarse fault on the first source stays latched
		mfail = 12'h002;
		step(3);
		mfail = 12'h000;
		step(3);
		chk({7'h00, refp}, 8'h01);
		rc(7'h05, 8'h02);
		// held single-cycle fault on the third source
		mfail = 12'h100;
		step(3);
		chk({5'h00, swf}, 8'h04);
		rc(7'h02, 8'hFC);
		wr(7'h0D, 8'h00);
		rc(7'h02, 8'hF8);
		wr(7'h21, 8'h00);
		chk({5'h00, swf}, 8'h00);
		mfail = 12'h000;
		// loop event and its pending flag
		evt = 8'h01;
		step(1);
		evt = 8'h00;
		wr(7'h0A, 8'h01);
		chk({7'h00, loopp}, 8'h01);
		rc(7'h03, 8'h01);
		chk({7'h00, loopp}, 8'h00);
		// writing ones clears only those sticky bits
		evt = 8'h06;
		step(1);
		evt = 8'h00;
		wr(7'h03, 8'h02);
		rc(7'h03, 8'h04);
		// live status, read-only and unmapped places
		rc(7'h10, 8'h3C);
		rc(7'h11, 8'hA5);
		rc(7'h14, 8'h5A);
		rc(7'h15, 8'hC3);
		wr(7'h10, 8'h00);
		rc(7'h10, 8'h3C);
		wr(7'h04, 8'h77);
		rc(7'h04, 8'h00);
		// pattern through every read-write register
		for (int i = 0; i < 18; i++) wr(RA[i], pat(RA[i]));
		for (int i = 0; i < 18; i++) rc(RA[i], pat(RA[i]));
		chk(pri_a, 8'h4B);
		chk(pri_b, 8'h5A);
		chk(lim_a, 8'h69);
		chk(psel, 8'h1E);
		chk(lim_b, 8'h78);
		chk(smsk, 8'hA5);
		chk(stim, 8'hC3);
		chk(filt, 8'hD2);
		chk(hold, 8'hE1);
		chk(wtr, 8'h2D);
		chk({5'h00, rev}, 8'h04);
		chk({4'h0, mode, src}, 8'h03);
		// burst write to consecutive places
		host.start();
		chk({7'h00, moe}, 8'h01);
		host.xbyte(8'h16, v);
		host.xbyte(8'h11, v);
		host.xbyte(8'h22, v);
		host.stop();
		chk({7'h00, moe}, 8'h00);
		rc(7'h16, 8'h11);
		rc(7'h17, 8'h22);
		// automatic mode follows the core, then pins take over
		asrc = 2'h2;
		wr(7'h1F, 8'h01);
		chk({4'h0, mode, src}, 8'h06);
		mpins = 2'h2;
		wr(7'h01, 8'h01);
		step(4);
		chk({6'h00, mode}, 8'h02);
		// precise window period
		gap(n);
		step(1);
		gap(n);
		chk(n[7:0], 8'(PRECISE_FREQUENCY_CHECK - 1));
		summarize();
	end
endmodule
`default_nettype wire
